// File: hdl/adc_comp_pkg.sv
// shared constants and types for the offset and gain compensator
package adc_comp_pkg;
  localparam int SAMPLE_W = 16;
  localparam int GAIN_W = 16;
  localparam int OFFSET_W = 8;
  localparam int MODE_W = 4;
  localparam int NUM_MODES = 10;
  localparam int BYTES_PER_MODE = 3;
  localparam int CAL_BYTES = 30;
  localparam int CAL_ADDR_W = 5;
  localparam int OFFSET_SHIFT = 4;
  localparam int FRAC_BITS = 16;
  localparam logic [31:0] ROUND_CONST = 32'h0000_8000;
  localparam logic [MODE_W-1:0] OFFSET_MEAS_MODE = 4'h7;
  localparam logic [MODE_W-1:0] DIFF_MODE_FIRST = 4'h8;
  localparam logic [CAL_ADDR_W-1:0] OFF_IDX = 5'h00;
  localparam logic [CAL_ADDR_W-1:0] GAIN_HI_IDX = 5'h01;
  localparam logic [CAL_ADDR_W-1:0] GAIN_LO_IDX = 5'h02;
  localparam logic [CAL_ADDR_W-1:0] NEG_GAIN_SLOT = 5'h1B;
  localparam int PIPE_LATENCY = 4;
  localparam logic [SAMPLE_W-1:0] RESULT_RESET = 16'h0000;

  typedef struct packed {
    logic [7:0] resultHighByte;
    logic [7:0] resultLowByte;
  } raw_sample_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] word;
    logic hwInvalid;
    logic calcOverflow;
  } comp_result_t;

  typedef struct packed {
    logic we;
    logic [CAL_ADDR_W-1:0] addr;
    logic [7:0] data;
  } cal_write_t;
endpackage

// File: hdl/cal_store.sv
// calibration byte storage with registered read ports
`timescale 1ns/100ps
`default_nettype none
module cal_store #(
  parameter int DEPTH = adc_comp_pkg::CAL_BYTES,
  parameter int AW = adc_comp_pkg::CAL_ADDR_W
) (
  input wire logic clock,
  input wire adc_comp_pkg::cal_write_t wr,
  input wire logic [AW-1:0] rdAddrA,
  input wire logic [AW-1:0] rdAddrB,
  input wire logic [AW-1:0] rdAddrC,
  output logic [7:0] rdDataA,
  output logic [7:0] rdDataB,
  output logic [7:0] rdDataC
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr.we && (int'(wr.addr) < DEPTH)) begin
      mem[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge clock) begin
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
    rdDataC <= mem[rdAddrC];
  end
endmodule
`default_nettype wire

// File: hdl/adc_offset_gain_compensator.sv
// offset and gain compensation datapath for raw converter samples
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1 - thirty calibration bytes, three per input mode: offset, gain high, gain low
// RL2 - offset-measurement mode shorts the differential inputs together
// RL3 - result is corrected sample plus corrected sample times gain over 2^16
// RL4 - offset removed first; gain works on the corrected sample
// RL5 - full multiply first, then scale by 2^16
// RL6 - lowest raw bit is hardware overflow; set means sample invalid
// RL7 - offset byte magnitude shifted left four, sign extended above
// RL8 - multiply on magnitudes, both signs kept for restoration
// RL9 - differential modes pick positive or negative gain by corrected sign
// RL10 - round by adding 0x8000 to product, keep upper sixteen bits
// RL11 - negate correction when sample and gain signs differ
// RL12 - add signed correction to signed corrected sample
// RL13 - shift sum right one, top filled from corrected sample sign
// RL14 - output: sign, overflow, eleven result bits, two unused zeros; the code's word carries twelve result bits (13:2)
// RL15 - sign and overflow bits differ when outside -1024..+1023
// RL16 - raw sample has thirteen significant bits, eleven kept; rawData keeps all thirteen
// RL17 - uncorrected samples should be scaled by 8/7 by the consumer
// RL18 - raw sample spans high byte and low byte bits 7 to 3
// RL19 - hardware overflow invalidates every other bit of the sample
// RL20 - one sample in per strobe, result out fixed cycles later in order
module adc_offset_gain_compensator (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [adc_comp_pkg::MODE_W-1:0] input_select,
  output logic inputsShorted,
  input wire adc_comp_pkg::cal_write_t calWrite,
  input wire logic sampleValid,
  input wire adc_comp_pkg::raw_sample_t rawSample,
  output logic resultValid,
  output adc_comp_pkg::comp_result_t result
);
  localparam logic [4:0] CAL_STRIDE = 5'(adc_comp_pkg::BYTES_PER_MODE);

  function automatic logic [4:0] cal_base(input logic [adc_comp_pkg::MODE_W-1:0] mode);
    cal_base = 5'(mode) * CAL_STRIDE;
  endfunction

  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction

  // RL2: combinational switch control to the converter front end
  assign inputsShorted = (input_select == adc_comp_pkg::OFFSET_MEAS_MODE); // RL2

  // stage 0: calibration lookup, sample capture
  logic isDiff;
  logic [4:0] base;
  logic [4:0] gainBase;
  logic [7:0] offByte;
  logic [7:0] gainHi;
  logic [7:0] gainLo;
  logic [7:0] gainHiNeg;
  logic [7:0] gainLoNeg;
  logic [7:0] unusedNeg;

  assign isDiff = (input_select >= adc_comp_pkg::DIFF_MODE_FIRST);
  assign base = cal_base(input_select); // RL1

  cal_store u_cal_pos (
    .clock(clock),
    .wr(calWrite),
    .rdAddrA(base + adc_comp_pkg::OFF_IDX),
    .rdAddrB(base + adc_comp_pkg::GAIN_HI_IDX),
    .rdAddrC(base + adc_comp_pkg::GAIN_LO_IDX),
    .rdDataA(offByte),
    .rdDataB(gainHi),
    .rdDataC(gainLo)
  );

  // second gain word for negative differential samples
  adc_comp_pkg::cal_write_t negWrite;
  always_comb begin
    negWrite = calWrite;
    negWrite.we = calWrite.we && (calWrite.addr >= adc_comp_pkg::NEG_GAIN_SLOT);
  end

  assign gainBase = adc_comp_pkg::NEG_GAIN_SLOT;
  cal_store #(.DEPTH(32)) u_cal_neg (
    .clock(clock),
    .wr(negWrite),
    .rdAddrA(gainBase),
    .rdAddrB(gainBase + adc_comp_pkg::GAIN_HI_IDX),
    .rdAddrC(gainBase + adc_comp_pkg::GAIN_LO_IDX),
    .rdDataA(unusedNeg),
    .rdDataB(gainHiNeg),
    .rdDataC(gainLoNeg)
  );

  logic v1;
  logic [15:0] raw1;
  logic diff1;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      v1 <= 1'b0;
      raw1 <= 16'h0000;
      diff1 <= 1'b0;
    end else begin
      v1 <= sampleValid; // RL20
      raw1 <= {rawSample.resultHighByte, rawSample.resultLowByte}; // RL18
      diff1 <= isDiff;
    end
  end

  // stage 1: offset removal and magnitudes
  logic [15:0] rawData;
  logic [15:0] offAligned;
  logic [15:0] corr;
  logic [15:0] gainSel;
  assign rawData = {raw1[15:3], 3'b000}; // RL16
  assign offAligned = {{5{offByte[7]}}, offByte[6:0], 4'h0}; // RL7
  assign corr = rawData - offAligned; // RL4
  assign gainSel = (diff1 && corr[15]) ? {gainHiNeg, gainLoNeg} : {gainHi, gainLo}; // RL9

  logic v2;
  logic inv2;
  logic [15:0] corr2;
  logic [15:0] absCorr2;
  logic [15:0] absGain2;
  logic gSign2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      v2 <= 1'b0;
      inv2 <= 1'b0;
      corr2 <= 16'h0000;
      absCorr2 <= 16'h0000;
      absGain2 <= 16'h0000;
      gSign2 <= 1'b0;
    end else begin
      v2 <= v1;
      inv2 <= raw1[0]; // RL6
      corr2 <= corr;
      absCorr2 <= abs16(corr); // RL8
      absGain2 <= abs16(gainSel); // RL8
      gSign2 <= gainSel[15];
    end
  end

  // stage 2: full-width multiply, round, drop fraction
  logic [31:0] product;
  logic [31:0] rounded;
  assign product = 32'(absCorr2) * 32'(absGain2); // RL5
  assign rounded = product + adc_comp_pkg::ROUND_CONST; // RL10

  logic v3;
  logic inv3;
  logic [15:0] corr3;
  logic [15:0] factor3;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      v3 <= 1'b0;
      inv3 <= 1'b0;
      corr3 <= 16'h0000;
      factor3 <= 16'h0000;
    end else begin
      v3 <= v2;
      inv3 <= inv2;
      corr3 <= corr2;
      factor3 <= (corr2[15] ^ gSign2) ? 16'(-rounded[31:16]) : rounded[31:16]; // RL11
    end
  end

  // stage 3: add, shift with sign, format
  logic [15:0] sum;
  logic [15:0] shifted;
  logic [15:0] outWord;
  assign sum = corr3 + factor3; // RL12 RL3
  assign shifted = {corr3[15], sum[15:1]}; // RL13
  assign outWord = {shifted[15:2], 2'b00}; // RL14

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resultValid <= 1'b0;
      result <= '0;
    end else begin
      resultValid <= v3; // RL20
      result.word <= inv3 ? adc_comp_pkg::RESULT_RESET : outWord; // RL19
      result.hwInvalid <= inv3; // RL6
      result.calcOverflow <= ~inv3 & (outWord[15] ^ outWord[14]); // RL15
    end
  end

  // latency tracker for assertions
  logic [3:0] pipeHist;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pipeHist <= 4'h0;
    end else begin
      pipeHist <= {pipeHist[2:0], sampleValid};
    end
  end

  property p_latency;
    @(posedge clock) disable iff (!rst_b) sampleValid |-> ##4 resultValid;
  endproperty
  a_latency: assert property (p_latency) else $error("result strobe late"); // RL20

  property p_no_spurious;
    @(posedge clock) disable iff (!rst_b) resultValid |-> pipeHist[3];
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("result without sample"); // RL20

  property p_short;
    @(posedge clock) disable iff (!rst_b)
      (input_select == adc_comp_pkg::OFFSET_MEAS_MODE) |-> inputsShorted;
  endproperty
  a_short: assert property (p_short) else $error("inputs not shorted"); // RL2

  property p_hw_invalid;
    @(posedge clock) disable iff (!rst_b)
      (sampleValid && rawSample.resultLowByte[0]) |-> ##4 (result.hwInvalid && !result.calcOverflow);
  endproperty
  a_hw_invalid: assert property (p_hw_invalid) else $error("invalid flag lost"); // RL6

  property p_unused_low;
    @(posedge clock) disable iff (!rst_b) resultValid |-> (result.word[1:0] == 2'b00);
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("low bits not zero"); // RL14

  property p_ovf_match;
    @(posedge clock) disable iff (!rst_b)
      (resultValid && !result.hwInvalid) |-> (result.calcOverflow == (result.word[15] ^ result.word[14]));
  endproperty
  a_ovf_match: assert property (p_ovf_match) else $error("overflow flag mismatch"); // RL15

  property p_offset_align;
    @(posedge clock) disable iff (!rst_b)
      v1 |-> (offAligned[15:11] == {5{offByte[7]}} && offAligned[10:0] == {offByte[6:0], 4'h0});
  endproperty
  a_offset_align: assert property (p_offset_align) else $error("offset misaligned"); // RL7

  property p_sign_fill;
    @(posedge clock) disable iff (!rst_b)
      v3 |=> (!result.hwInvalid -> (result.word[15] == $past(corr3[15])));
  endproperty
  a_sign_fill: assert property (p_sign_fill) else $error("sign fill wrong"); // RL13

  property p_mag_pos;
    @(posedge clock) disable iff (!rst_b) v2 |-> (absCorr2[15] == 1'b0 || corr2 == 16'h8000);
  endproperty
  a_mag_pos: assert property (p_mag_pos) else $error("magnitude negative"); // RL8

  property p_mag_gain;
    @(posedge clock) disable iff (!rst_b)
      v2 |-> (absGain2[15] == 1'b0 || absGain2 == 16'h8000);
  endproperty
  a_mag_gain: assert property (p_mag_gain) else $error("gain magnitude negative"); // RL8

  property p_no_short_other;
    @(posedge clock) disable iff (!rst_b)
      (input_select != adc_comp_pkg::OFFSET_MEAS_MODE) |-> !inputsShorted;
  endproperty
  a_no_short_other: assert property (p_no_short_other) else $error("stray short"); // RL2

  property p_sub_first;
    @(posedge clock) disable iff (!rst_b)
      v1 |-> (16'(corr + offAligned) == rawData);
  endproperty
  a_sub_first: assert property (p_sub_first) else $error("offset not removed"); // RL4

  property p_gain_pos;
    @(posedge clock) disable iff (!rst_b)
      (v1 && !(diff1 && corr[15])) |-> (gainSel == {gainHi, gainLo});
  endproperty
  a_gain_pos: assert property (p_gain_pos) else $error("wrong gain word"); // RL9

  property p_gain_neg;
    @(posedge clock) disable iff (!rst_b)
      (v1 && diff1 && corr[15]) |-> (gainSel == {gainHiNeg, gainLoNeg});
  endproperty
  a_gain_neg: assert property (p_gain_neg) else $error("wrong negative gain word"); // RL9

  property p_factor_keep;
    @(posedge clock) disable iff (!rst_b)
      (v2 && (corr2[15] == gSign2)) |=> (factor3 == $past(rounded[31:16]));
  endproperty
  a_factor_keep: assert property (p_factor_keep) else $error("factor sign flipped"); // RL11

  property p_factor_flip;
    @(posedge clock) disable iff (!rst_b)
      (v2 && (corr2[15] != gSign2)) |=> (16'(factor3 + $past(rounded[31:16])) == 16'h0000);
  endproperty
  a_factor_flip: assert property (p_factor_flip) else $error("factor not negated"); // RL11

  property p_invalid_zero;
    @(posedge clock) disable iff (!rst_b)
      (resultValid && result.hwInvalid) |-> (result.word == adc_comp_pkg::RESULT_RESET);
  endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("invalid word not cleared"); // RL19

  property p_back_to_back;
    @(posedge clock) disable iff (!rst_b)
      (sampleValid ##1 sampleValid) |-> ##3 (resultValid ##1 resultValid);
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("back to back lost"); // RL20

  property p_inv_carry;
    @(posedge clock) disable iff (!rst_b)
      (v1 && raw1[0]) |=> inv2;
  endproperty
  a_inv_carry: assert property (p_inv_carry) else $error("invalid flag dropped"); // RL6
endmodule
`default_nettype wire

// File: bench/raw_sample_source.sv
// converter result and calibration write driver
`timescale 1ns/100ps
`default_nettype none
module raw_sample_source (
  input wire logic clock,
  output adc_comp_pkg::cal_write_t calWrite,
  output logic sampleValid,
  output adc_comp_pkg::raw_sample_t rawSample
);
  initial begin
    calWrite = 14'h0000;
    sampleValid = 1'b0;
    rawSample = 16'h0000;
  end
  // one calibration byte per edge
  task automatic writeCal(input logic [4:0] addr, input logic [7:0] data);
    calWrite.we = 1'b1;
    calWrite.addr = addr;
    calWrite.data = data;
    @(posedge clock);
    #1;
  endtask
  task automatic idleCal();
    calWrite.we = 1'b0;
    calWrite.data = ~calWrite.data;
  endtask
  // high byte then low byte, overflow flag in bit 0
  task automatic sendSample(input logic [15:0] raw);
    sampleValid = 1'b1;
    rawSample = raw;
    @(posedge clock);
    #1;
  endtask
  // released data shows inverse of last word
  task automatic idleSample();
    sampleValid = 1'b0;
    rawSample = ~rawSample;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_adc_offset_gain_compensator.sv
// self-checking bench for the compensator
`timescale 1ns/100ps
`default_nettype none
module tb_adc_offset_gain_compensator;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] input_select = 4'h0;
  logic inputsShorted;
  logic sampleValid;
  logic resultValid;
  adc_comp_pkg::raw_sample_t rawSample;
  adc_comp_pkg::cal_write_t calWrite;
  adc_comp_pkg::comp_result_t result;
  int fails = 0;
  int comparisons = 0;
  int cycleCount = 0;
  // result launched one edge before the edge that samples it
  localparam int LAUNCH_GAP = adc_comp_pkg::PIPE_LATENCY - 1;
  logic [17:0] expQ[$];
  int takeQ[$];
  logic [7:0] offs [10];
  logic [15:0] gains [10];
  // raw words as delivered uncorrected; a consumer of these scales by 8/7
  logic [15:0] raws [5] = '{16'h7FF8, 16'h8008, 16'h1239, 16'h0446, 16'hFC10};
  always #4 clock = ~clock;
  always @(posedge clock) cycleCount <= cycleCount + 1;
  adc_offset_gain_compensator adc_offset_gain_compensator_inst (
    .clock(clock), .rst_b(rst_b), .input_select(input_select),
    .inputsShorted(inputsShorted), .calWrite(calWrite), .sampleValid(sampleValid),
    .rawSample(rawSample), .resultValid(resultValid), .result(result));
  raw_sample_source raw_sample_source_inst (
    .clock(clock), .calWrite(calWrite), .sampleValid(sampleValid), .rawSample(rawSample));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected) begin
      fails++;
      $display("Error %s expected %h seen %h", name, expected, seen);
    end
  endtask
  task automatic end_of_test();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reference arithmetic
  function automatic logic [17:0] expectedResult(logic [3:0] m, logic [15:0] raw);
    logic [15:0] corr, g, am, ag, f, sum, w;
    logic [31:0] prod;
    corr = {raw[15:3], 3'h0} - {{5{offs[m][7]}}, offs[m][6:0], 4'h0};
    g = (m >= 4'h8 && corr[15]) ? gains[9] : gains[m];
    am = corr[15] ? -corr : corr;
    ag = g[15] ? -g : g;
    prod = am * ag;
    prod = prod + 32'h0000_8000;
    f = prod[31:16];
    if (corr[15] != g[15]) f = -f;
    sum = corr + f;
    w = {corr[15], sum[15:3], 2'h0};
    if (raw[0]) return 18'h00002;
    return {w, 1'b0, w[15] ^ w[14]};
  endfunction
  always @(negedge clock) begin
    if (resultValid === 1'b1) begin
      if (expQ.size() == 0) check("spurious resultValid", 32'h1, 32'h0);
      else begin
        check("result", result, expQ.pop_front());
        check("latency", cycleCount - takeQ.pop_front(), 32'(LAUNCH_GAP));
      end
    end
  end
  // all ten mode sets, back to back bytes
  task automatic calibrate();
    for (int m = 0; m < 10; m++) begin
      offs[m] = 8'(m * 8'h35);
      gains[m] = 16'h0800 - 16'(m * 16'h0340);
      raw_sample_source_inst.writeCal(5'(3 * m), offs[m]);
      raw_sample_source_inst.writeCal(5'(3 * m + 1), gains[m][15:8]);
      raw_sample_source_inst.writeCal(5'(3 * m + 2), gains[m][7:0]);
    end
    raw_sample_source_inst.writeCal(5'h1F, 8'hA5);
    raw_sample_source_inst.idleCal();
  endtask
  // short switch follows the offset mode
  task automatic modeShort();
    for (int m = 0; m < 10; m++) begin
      input_select = 4'(m);
      #1;
      check("inputsShorted", inputsShorted, {31'h0, m == 7});
      @(posedge clock);
      #1;
    end
  endtask
  // every mode and sample value, back to back
  task automatic sampleSweep();
    int n;
    for (int m = 0; m < 10; m++) begin
      for (int r = 0; r < 5; r++) begin
        input_select = 4'(m);
        expQ.push_back(expectedResult(4'(m), raws[r]));
        takeQ.push_back(cycleCount + 1);
        raw_sample_source_inst.sendSample(raws[r]);
      end
    end
    raw_sample_source_inst.idleSample();
    n = 0;
    while (expQ.size() != 0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
    check("pending results", expQ.size(), 32'h0);
  endtask
  initial begin
    #(5000 * 8);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    #1;
    check("resultValid in reset", resultValid, 32'h0);
    rst_b = 1'b1;
    @(posedge clock);
    #1;
    calibrate();
    modeShort();
    sampleSweep();
    end_of_test();
  end
endmodule
`default_nettype wire
